// ==== pkg/pcgfo_consts.svh ====
`ifndef PCGFO_CONSTS_SVH
`define PCGFO_CONSTS_SVH
// Register word addresses
`define PCGFO_ADDR_PDC   16'hf1d4
`define PCGFO_ADDR_FOC   16'hffaa
`define PCGFO_ADDR_REL   16'hf1c0
`define PCGFO_ADDR_PIN   16'hf1c2
// Reset values and implemented bits
`define PCGFO_PDC_RST    16'h0000
`define PCGFO_PDC_MASK   16'he2cf
`define PCGFO_FOC_RST    16'h0000
`define PCGFO_PIN_RST    3'h0
`define PCGFO_ZERO16     16'h0000
// Peripheral disable bit positions
`define PCGFO_BIT_CAN1   13
`define PCGFO_BIT_CAN2   14
`define PCGFO_BIT_PCD    15
// Frequency output control fields
`define PCGFO_FO_EN      15
`define PCGFO_FO_SS      14
`define PCGFO_FO_RV_HI   13
`define PCGFO_FO_RV_LO   8
`define PCGFO_FO_TL      6
`define PCGFO_FO_CNT_HI  5
`define PCGFO_FO_CNT_LO  0
`define PCGFO_CNT_ZERO   6'h00
// Pin control fields
`define PCGFO_PIN_LATCH  0
`define PCGFO_PIN_DIR    1
`define PCGFO_PIN_SYSCLK_OUT_ENABLE  2
// Release field and unlock values
`define PCGFO_REL_HI     3
`define PCGFO_REL_LO     0
`define PCGFO_REL_ZERO   4'h0
`define PCGFO_UNLOCK1    4'h9
`define PCGFO_UNLOCK2    4'h3
`define PCGFO_UNLOCK3    4'h7
`endif

// ==== pkg/pcgfo_pkg.sv ====
package pcgfo_pkg;
    // Register port request, one cycle per access
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } pcgfo_bus_type;
    // Unlock sequence progress
    typedef enum logic [1:0] {
        UL_IDLE = 2'b00,
        UL_S1   = 2'b01,
        UL_S2   = 2'b10,
        UL_OPEN = 2'b11
    } pcgfo_ul_type;
endpackage

// ==== src/pcgfo_top.sv ====
// Chosen here: strobed register access.
`timescale 1ns/1ps
// Functional notes
// - Disable bits stop clocks of listed peripherals
// - Disabled generic peripheral registers stay accessible
// - Extension-bus peripheral blocked when disabled anyhow
// - Disabled peripheral pins hold last level
// - Clearing CAN disable issues internal reset
// - Disable register locked after end-of-init
// - Driver off stops all fed peripheral clocks
// - Driver off: clock output high, frequency runs
// - Interrupt requests recognized with driver off
// - Driver off freezes port outputs and inputs
// - Driver off blocks generic peripheral registers
// - Enable rising loads counter from reload
// - Enable cleared: stop once output low
// - Counter runs on CPU clock
// - Underflow copies reload field into counter
// - Underflow toggles latch, latch readable
// - Select picks toggle latch or raw
// - Raw output one cycle high per period
// - Frequency output ignores driver disable
// - Shared pin priority: clock, frequency, port
// - Release writes 9,3,7 open one write
`include "pcgfo_consts.svh"
module pcgfo_top
    import pcgfo_pkg::*;
#(
    parameter int PIN_W  = 4,   // Output pins per peripheral slot
    parameter int PORT_W = 8,   // General port width
    parameter int IRQ_W  = 8    // Interrupt request lines
) (
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    input  wire pcgfo_bus_type         bus,
    output logic [15:0]                rdata_r,
    input  wire logic                  end_of_init_instruction_pulse,
    output logic [15:0]                periph_clk_en_r,
    output logic                       gen_reg_access_en_r,
    output logic [1:0]                 xbus_access_en_r,
    output logic [1:0]                 can_reset_r,
    input  wire logic [16*PIN_W-1:0]   periph_out_in,
    output logic [16*PIN_W-1:0]        periph_pins_r,
    input  wire logic [IRQ_W-1:0]      irq_in,
    output logic [IRQ_W-1:0]           irq_out_r,
    input  wire logic [PORT_W-1:0]     port_latch_in,
    output logic [PORT_W-1:0]          port_pin_out_r,
    input  wire logic [PORT_W-1:0]     port_pin_in,
    output logic [PORT_W-1:0]          port_in_latched_r,
    output logic                       sysclk_out_r,
    output logic                       programmable_freq_output_r,
    output logic                       shared_pin_out_r,
    output logic                       shared_pin_oe_r,
    input  wire logic                  shared_pin_in
);

    logic [15:0]        pdc_r;           // Peripheral disable control
    logic               locked_r;        // Set by end of initialisation
    pcgfo_ul_type       ul_r;            // Unlock progress
    logic [3:0]         rel_r;           // Release field, last write; cleared when a release is used
    logic [2:0]         pin_r;           // Latch, direction, clock out enable
    logic               fo_en_r;         // Frequency output enable
    logic               fo_ss_r;         // Signal select
    logic [5:0]         fo_rv_r;         // Reload value
    logic [5:0]         fo_cnt_r;        // Down counter
    logic               fo_tl_r;         // Toggle latch
    logic               fo_run_r;        // Counter running
    logic [PORT_W-1:0]  pin_s1_r;        // Port input sync, first stage
    logic [PORT_W-1:0]  pin_s2_r;        // Port input sync, second stage
    logic               sh_s1_r;         // Shared pin sync, first stage
    logic               sh_s2_r;         // Shared pin sync, second stage

    // Decoded accesses
    logic wr_pdc;
    logic wr_foc;
    logic wr_rel;
    logic wr_pin;
    logic pdc_ok;
    logic pcd_off;
    logic fo_uf;
    logic fo_tl_nxt;
    logic programmable_freq_output_nxt;
    logic en_rise;
    logic [15:0] pdc_nxt;

    assign wr_pdc  = bus.wr && (bus.addr == `PCGFO_ADDR_PDC);
    assign wr_foc  = bus.wr && (bus.addr == `PCGFO_ADDR_FOC);
    assign wr_rel  = bus.wr && (bus.addr == `PCGFO_ADDR_REL);
    assign wr_pin  = bus.wr && (bus.addr == `PCGFO_ADDR_PIN);
    assign pcd_off = pdc_r[`PCGFO_BIT_PCD];
    // Write permitted before lock or once after a full release
    assign pdc_ok  = wr_pdc && (!locked_r || (ul_r == UL_OPEN));
    assign pdc_nxt = bus.wdata & `PCGFO_PDC_MASK;

    // Lock flag, sticky until reset
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            locked_r <= 1'b0;
        end else if (end_of_init_instruction_pulse) begin
            locked_r <= 1'b1;
        end
    end

    // Unlock sequence tracker and release field
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ul_r  <= UL_IDLE;
            rel_r <= `PCGFO_REL_ZERO;
        end else if (wr_rel) begin
            // Field shows the last value written
            rel_r <= bus.wdata[`PCGFO_REL_HI:`PCGFO_REL_LO];
            case (ul_r)
                UL_S1: begin
                    if (bus.wdata[`PCGFO_REL_HI:`PCGFO_REL_LO] == `PCGFO_UNLOCK2) begin
                        ul_r <= UL_S2;
                    end else if (bus.wdata[`PCGFO_REL_HI:`PCGFO_REL_LO] == `PCGFO_UNLOCK1) begin
                        ul_r <= UL_S1;
                    end else begin
                        ul_r <= UL_IDLE;
                    end
                end
                UL_S2: begin
                    if (bus.wdata[`PCGFO_REL_HI:`PCGFO_REL_LO] == `PCGFO_UNLOCK3) begin
                        ul_r <= UL_OPEN;
                    end else if (bus.wdata[`PCGFO_REL_HI:`PCGFO_REL_LO] == `PCGFO_UNLOCK1) begin
                        ul_r <= UL_S1;
                    end else begin
                        ul_r <= UL_IDLE;
                    end
                end
                default: begin
                    // Any state: a first step restarts the sequence
                    if (bus.wdata[`PCGFO_REL_HI:`PCGFO_REL_LO] == `PCGFO_UNLOCK1) begin
                        ul_r <= UL_S1;
                    end else begin
                        ul_r <= UL_IDLE;
                    end
                end
            endcase
        end else if (wr_pdc && (ul_r == UL_OPEN)) begin
            // Single write consumed; hardware clears the field
            ul_r  <= UL_IDLE;
            rel_r <= `PCGFO_REL_ZERO;
        end else if (wr_pdc && (ul_r != UL_IDLE)) begin
            // A protected write in mid-sequence aborts it
            ul_r  <= UL_IDLE;
        end
    end

    // Peripheral disable register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pdc_r <= `PCGFO_PDC_RST;
        end else if (pdc_ok) begin
            pdc_r <= pdc_nxt;
        end
    end

    // Clock enables; every slot is fed by the peripheral clock driver
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            periph_clk_en_r <= ~`PCGFO_ZERO16;
        end else begin
            periph_clk_en_r <= ~pdc_r & {16{!pcd_off}};
        end
    end

    // Register access permissions for attached peripherals
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            gen_reg_access_en_r <= 1'b1;
            xbus_access_en_r    <= 2'b11;
        end else begin
            // Generic ones ignore their own bit, only the driver counts
            gen_reg_access_en_r <= !pcd_off;
            xbus_access_en_r[0] <= !pdc_r[`PCGFO_BIT_CAN1] && !pcd_off;
            xbus_access_en_r[1] <= !pdc_r[`PCGFO_BIT_CAN2] && !pcd_off;
        end
    end

    // CAN re-activation reset: one pulse when a disable bit clears
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            can_reset_r <= 2'b00;
        end else begin
            can_reset_r[0] <= pdc_ok && pdc_r[`PCGFO_BIT_CAN1] && !pdc_nxt[`PCGFO_BIT_CAN1];
            can_reset_r[1] <= pdc_ok && pdc_r[`PCGFO_BIT_CAN2] && !pdc_nxt[`PCGFO_BIT_CAN2];
        end
    end

    // Peripheral pin holding, one slot per disable bit
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_hold
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    periph_pins_r[gi*PIN_W +: PIN_W] <= '0;
                end else if (periph_clk_en_r[gi]) begin
                    periph_pins_r[gi*PIN_W +: PIN_W] <= periph_out_in[gi*PIN_W +: PIN_W];
                end
                // Otherwise the pins keep the level seen at disable time
            end
        end
    endgenerate

    // Interrupt requests pass regardless of the driver state
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_out_r <= '0;
        end else begin
            irq_out_r <= irq_in;
        end
    end

    // Port input synchronisers
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            sh_s1_r  <= 1'b0;
            sh_s2_r  <= 1'b0;
        end else begin
            pin_s1_r <= port_pin_in;
            pin_s2_r <= pin_s1_r;
            sh_s1_r  <= shared_pin_in;
            sh_s2_r  <= sh_s1_r;
        end
    end

    // Port latches gated by the driver; frozen while it is off
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            port_pin_out_r    <= '0;
            port_in_latched_r <= '0;
        end else if (!pcd_off) begin
            port_pin_out_r    <= port_latch_in;
            port_in_latched_r <= pin_s2_r;
        end
    end

    // System clock output: half rate from this clock, parked high with driver off
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sysclk_out_r <= 1'b1;
        end else if (pcd_off) begin
            sysclk_out_r <= 1'b1;
        end else begin
            sysclk_out_r <= !sysclk_out_r;
        end
    end

    // Pin control register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pin_r <= `PCGFO_PIN_RST;
        end else if (wr_pin) begin
            pin_r <= bus.wdata[`PCGFO_PIN_SYSCLK_OUT_ENABLE:`PCGFO_PIN_LATCH];
        end
    end

    // Frequency generator next values; not gated by the driver
    assign fo_uf     = fo_run_r && (fo_cnt_r == `PCGFO_CNT_ZERO);
    assign fo_tl_nxt = fo_tl_r ^ fo_uf;
    // Toggle latch for 50% duty, else raw underflow pulse
    assign programmable_freq_output_nxt  = fo_run_r && (fo_ss_r ? fo_uf : fo_tl_nxt);
    assign en_rise   = wr_foc && bus.wdata[`PCGFO_FO_EN] && !fo_en_r;

    // Control fields of the frequency output register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fo_en_r <= 1'b0;
            fo_ss_r <= 1'b0;
            fo_rv_r <= `PCGFO_CNT_ZERO;
        end else if (wr_foc) begin
            fo_en_r <= bus.wdata[`PCGFO_FO_EN];
            fo_ss_r <= bus.wdata[`PCGFO_FO_SS];
            fo_rv_r <= bus.wdata[`PCGFO_FO_RV_HI:`PCGFO_FO_RV_LO];
        end
    end

    // Down counter on the CPU clock, so it follows any slowdown
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fo_cnt_r <= `PCGFO_CNT_ZERO;
        end else if (en_rise) begin
            fo_cnt_r <= bus.wdata[`PCGFO_FO_RV_HI:`PCGFO_FO_RV_LO];
        end else if (fo_uf) begin
            fo_cnt_r <= fo_rv_r;
        end else if (wr_foc) begin
            // Direct writes take effect but may upset the count
            fo_cnt_r <= bus.wdata[`PCGFO_FO_CNT_HI:`PCGFO_FO_CNT_LO];
        end else if (fo_run_r) begin
            fo_cnt_r <= fo_cnt_r - 6'h01;
        end
    end

    // Toggle latch, run flag and registered output
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fo_tl_r  <= 1'b0;
            fo_run_r <= 1'b0;
            programmable_freq_output_r   <= 1'b0;
        end else begin
            programmable_freq_output_r <= programmable_freq_output_nxt;
            if (en_rise) begin
                // Fresh start from a low output gives whole periods
                fo_tl_r  <= 1'b0;
                fo_run_r <= 1'b1;
            end else begin
                fo_tl_r  <= (wr_foc && !fo_uf) ? bus.wdata[`PCGFO_FO_TL] : fo_tl_nxt;
                // Keep going after disable until the output is low
                fo_run_r <= fo_run_r && ((wr_foc ? bus.wdata[`PCGFO_FO_EN] : fo_en_r)
                            || programmable_freq_output_nxt);
            end
        end
    end

    // Shared pin priority: clock output, frequency output, port latch
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            shared_pin_out_r <= 1'b0;
            shared_pin_oe_r  <= 1'b0;
        end else begin
            shared_pin_oe_r <= pin_r[`PCGFO_PIN_DIR] || pin_r[`PCGFO_PIN_SYSCLK_OUT_ENABLE];
            if (pin_r[`PCGFO_PIN_SYSCLK_OUT_ENABLE]) begin
                shared_pin_out_r <= sysclk_out_r;
            end else if (fo_en_r || fo_run_r) begin
                shared_pin_out_r <= programmable_freq_output_nxt;
            end else if (!pcd_off) begin
                // Latch zero keeps the inactive level when stopped
                shared_pin_out_r <= pin_r[`PCGFO_PIN_LATCH];
            end
        end
    end

    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= `PCGFO_ZERO16;
        end else if (bus.rd) begin
            case (bus.addr)
                `PCGFO_ADDR_PDC: rdata_r <= pdc_r;
                `PCGFO_ADDR_FOC: rdata_r <= {fo_en_r, fo_ss_r, fo_rv_r, 1'b0, fo_tl_r, fo_cnt_r};
                `PCGFO_ADDR_REL: rdata_r <= {12'h000, rel_r};
                `PCGFO_ADDR_PIN: rdata_r <= {12'h000, sh_s2_r, pin_r};
                default:         rdata_r <= `PCGFO_ZERO16;
            endcase
        end else begin
            rdata_r <= `PCGFO_ZERO16;
        end
    end

    // Checks
    sequence s_pcd_off2;
        pcd_off [*2];
    endsequence

    sequence s_uf_nonzero;
        fo_uf && fo_ss_r && (fo_rv_r != `PCGFO_CNT_ZERO) && !wr_foc;
    endsequence

    AST_PCD_STOPS_ALL: assert property (@(posedge ref_clk) disable iff (!nrst)
        pcd_off |=> (periph_clk_en_r == `PCGFO_ZERO16))
        else $error("clock enable left on with driver off");

    AST_BIT_STOPS_ONE: assert property (@(posedge ref_clk) disable iff (!nrst)
        pdc_r[0] |=> !periph_clk_en_r[0])
        else $error("disabled converter clock still on");

    AST_LOCKED_WRITE: assert property (@(posedge ref_clk) disable iff (!nrst)
        (wr_pdc && locked_r && (ul_r != UL_OPEN)) |=> $stable(pdc_r))
        else $error("locked register changed");

    AST_UNLOCK_ONCE: assert property (@(posedge ref_clk) disable iff (!nrst)
        (wr_pdc && !wr_rel && (ul_r == UL_OPEN))
        |=> (pdc_r == $past(pdc_nxt)) && (ul_r == UL_IDLE) && (rel_r == `PCGFO_REL_ZERO))
        else $error("released write not taken once");

    AST_CAN_RESET: assert property (@(posedge ref_clk) disable iff (!nrst)
        $fell(pdc_r[`PCGFO_BIT_CAN1]) |-> can_reset_r[0])
        else $error("no reset on CAN re-enable");

    AST_XBUS_BLOCK: assert property (@(posedge ref_clk) disable iff (!nrst)
        (pdc_r[`PCGFO_BIT_CAN2] || pcd_off) |=> !xbus_access_en_r[1])
        else $error("extension peripheral accessible while off");

    AST_GEN_ACCESS: assert property (@(posedge ref_clk) disable iff (!nrst)
        pcd_off |=> !gen_reg_access_en_r)
        else $error("generic access with driver off");

    AST_PIN_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!periph_clk_en_r[0]) |=> $stable(periph_pins_r[PIN_W-1:0]))
        else $error("disabled peripheral pins moved");

    AST_PORT_FREEZE: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_pcd_off2 |-> $stable(port_pin_out_r) && $stable(port_in_latched_r))
        else $error("port moved with driver off");

    AST_SYSTEM_CLOCK_OUTPUT_HIGH: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_pcd_off2 |-> sysclk_out_r)
        else $error("clock output not high");

    AST_IRQ_PASS: assert property (@(posedge ref_clk) disable iff (!nrst)
        1'b1 |=> (irq_out_r == $past(irq_in)))
        else $error("interrupt request lost");

    AST_START_LOAD: assert property (@(posedge ref_clk) disable iff (!nrst)
        en_rise |=> fo_run_r && !fo_tl_r
            && (fo_cnt_r == $past(bus.wdata[`PCGFO_FO_RV_HI:`PCGFO_FO_RV_LO])))
        else $error("start did not load reload value");

    AST_RELOAD_TOGGLE: assert property (@(posedge ref_clk) disable iff (!nrst)
        (fo_uf && !wr_foc) |=> (fo_cnt_r == $past(fo_rv_r)) && (fo_tl_r != $past(fo_tl_r)))
        else $error("underflow did not reload and toggle");

    AST_RAW_ONE_CYCLE: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_uf_nonzero |=> programmable_freq_output_r ##1 !programmable_freq_output_r)
        else $error("raw output high longer than one cycle");

    AST_STOP_LOW: assert property (@(posedge ref_clk) disable iff (!nrst)
        (fo_run_r && !fo_en_r && !wr_foc && !programmable_freq_output_nxt) |=> !fo_run_r && !programmable_freq_output_r)
        else $error("counter not stopped at low output");

    AST_PIN_PRIO: assert property (@(posedge ref_clk) disable iff (!nrst)
        pin_r[`PCGFO_PIN_SYSCLK_OUT_ENABLE] |=> (shared_pin_out_r == $past(sysclk_out_r)))
        else $error("shared pin not on clock output");

endmodule // pcgfo_top

// ==== test/pcgfo_ext_load.sv ====
`timescale 1ns/1ps
// External circuit clocked from the shared pin; counts rising edges it sees while the pin is driven
module pcgfo_ext_load (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        pin_drv,
    input  wire logic        pin_oe,
    output logic             pin_level,
    output logic [15:0]      rise_cnt
);
    logic prev_r;  // Last sampled pin level
    logic last_r;  // Last driven level, to float away from it
    // Undriven pin shows the inverse of its last value, no pull resistor
    assign pin_level = pin_oe ? pin_drv : ~last_r;
    // Edge counting only while the device drives the pin
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prev_r   <= 1'b0;
            last_r   <= 1'b0;
            rise_cnt <= 16'h0000;
        end else begin
            prev_r <= pin_level;
            if (pin_oe) begin
                last_r <= pin_drv;
            end
            if (pin_oe && pin_level && !prev_r) begin
                rise_cnt <= rise_cnt + 16'h0001;
            end
        end
    end
endmodule // pcgfo_ext_load

// ==== test/pcgfo_top_tb_top.sv ====
`timescale 1ns/1ps
`include "pcgfo_consts.svh"
module pcgfo_top_tb_top
    import pcgfo_pkg::*;
;
    logic ref_clk = 1'b0, nrst = 1'b0, end_of_init_instruction_pulse = 1'b0;
    pcgfo_bus_type bus = '0;
    logic [15:0] rdata_r, periph_clk_en_r, rise_cnt, d0, d1;
    logic        gen_reg_access_en_r, sysclk_out_r, programmable_freq_output_r, pin_out, pin_oe, pin_lvl;
    logic [1:0]  xbus_access_en_r, can_reset_r;
    logic [63:0] periph_out_in = '0, periph_pins_r;
    logic [7:0]  irq_in = '0, irq_out_r, port_latch_in = '0, port_pin_out_r;
    logic [7:0]  port_pin_in = '0, port_in_latched_r;
    int error_cnt = 0, checks = 0, hi, rc, n;
    always #2.5 ref_clk = ~ref_clk;  // 200 MHz CPU clock
    pcgfo_top pcgfo_top_i (.ref_clk(ref_clk), .nrst(nrst), .bus(bus), .rdata_r(rdata_r),
        .end_of_init_instruction_pulse(end_of_init_instruction_pulse), .periph_clk_en_r(periph_clk_en_r),
        .gen_reg_access_en_r(gen_reg_access_en_r), .xbus_access_en_r(xbus_access_en_r),
        .can_reset_r(can_reset_r), .periph_out_in(periph_out_in),
        .periph_pins_r(periph_pins_r), .irq_in(irq_in), .irq_out_r(irq_out_r),
        .port_latch_in(port_latch_in), .port_pin_out_r(port_pin_out_r),
        .port_pin_in(port_pin_in), .port_in_latched_r(port_in_latched_r),
        .sysclk_out_r(sysclk_out_r), .programmable_freq_output_r(programmable_freq_output_r), .shared_pin_out_r(pin_out),
        .shared_pin_oe_r(pin_oe), .shared_pin_in(pin_lvl));
    pcgfo_ext_load pcgfo_ext_load_i (.ref_clk(ref_clk), .nrst(nrst), .pin_drv(pin_out),
        .pin_oe(pin_oe), .pin_level(pin_lvl), .rise_cnt(rise_cnt));
    // Print counts and verdict, then stop
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic clk(int k);
        repeat (k) @(posedge ref_clk);
    endtask
    // One-cycle write strobe
    task automatic wr(logic [15:0] a, logic [15:0] v);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(logic [15:0] a, output logic [15:0] v);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1 v = rdata_r;
    endtask
    // Settle, then count output highs and pin rises over k cycles
    task automatic measure(int k);
        logic [15:0] r0;
        clk(8);
        #1 r0 = rise_cnt;
        hi = 0;
        repeat (k) begin
            @(posedge ref_clk);
            #1 if (programmable_freq_output_r === 1'b1) hi++;
        end
        rc = int'(rise_cnt - r0);
    endtask
    task automatic t_reset();
        rd(`PCGFO_ADDR_PDC, d0); chk("pdc rst", d0, 16'h0000);
        rd(`PCGFO_ADDR_FOC, d0); chk("foc rst", d0, 16'h0000);
        rd(16'h0100, d0); chk("unmapped", d0, 16'h0000);
        chk("clk en rst", periph_clk_en_r, 16'hffff);
    endtask
    task automatic t_pdc();
        wr(`PCGFO_ADDR_PDC, 16'hffff);
        rd(`PCGFO_ADDR_PDC, d0); chk("pdc mask", d0, 16'he2cf);
        @(posedge ref_clk) irq_in <= 8'h3c;
        port_latch_in <= 8'ha5;
        port_pin_in <= 8'h5a;
        clk(4);
        chk("clk en off", periph_clk_en_r, 16'h0000);
        chk("port in", port_in_latched_r, 8'h00);
        chk("gen acc", gen_reg_access_en_r, 1'b0);
        chk("xbus acc", xbus_access_en_r, 2'b00);
        chk("port out", port_pin_out_r, 8'h00);
        chk("irq", irq_out_r, 8'h3c);
        chk("sysclk", sysclk_out_r, 1'b1);
        clk(1); chk("sysclk", sysclk_out_r, 1'b1);
        wr(`PCGFO_ADDR_PDC, 16'h2000); clk(4);
        chk("clk en can1", periph_clk_en_r, 16'hdfff);
        chk("gen acc", gen_reg_access_en_r, 1'b1);
        chk("xbus acc", xbus_access_en_r, 2'b10);
        chk("port out", port_pin_out_r, 8'ha5);
        chk("port in", port_in_latched_r, 8'h5a);
        wr(`PCGFO_ADDR_PDC, 16'h0000);
        hi = 0;
        for (n = 0; n < 5; n++) begin
            #1 if (can_reset_r === 2'b01) hi = 1;
            @(posedge ref_clk);
        end
        chk("can reset", hi, 1);
    endtask
    task automatic t_hold();
        periph_out_in <= {16{4'h3}}; clk(3);
        wr(`PCGFO_ADDR_PDC, 16'h0001); clk(3);
        periph_out_in <= {16{4'hc}}; clk(3);
        chk("adc pins", periph_pins_r[3:0], 4'h3);
        chk("async pins", periph_pins_r[7:4], 4'hc);
        wr(`PCGFO_ADDR_PDC, 16'h0000);
    endtask
    task automatic t_programmable_freq_output();
        wr(`PCGFO_ADDR_PIN, 16'h0002);
        wr(`PCGFO_ADDR_FOC, 16'hc200);
        for (n = 1; n < 20; n++) begin
            @(posedge ref_clk);
            #1 if (programmable_freq_output_r === 1'b1) break;
        end
        if (n == 20) begin error_cnt++; give_verdict(); end
        chk("first high", n, 3);
        measure(60); chk("raw highs", hi, 20); chk("pin rises", rc, 20);
        rd(`PCGFO_ADDR_FOC, d0); chk("foc ctl", d0[15:8], 8'hc2);
        wr(`PCGFO_ADDR_FOC, 16'h8200);
        measure(60); chk("tl highs", hi, 30); chk("pin rises", rc, 10);
        rd(`PCGFO_ADDR_FOC, d0); clk(1); rd(`PCGFO_ADDR_FOC, d1);
        chk("latch flips", d0[6] ^ d1[6], 1'b1);
        wr(`PCGFO_ADDR_PDC, 16'h8000);
        measure(60); chk("drv off", hi, 30);
        wr(`PCGFO_ADDR_PDC, 16'h0000);
        wr(`PCGFO_ADDR_FOC, 16'hc000);
        measure(60); chk("rv0 highs", hi, 60);
        wr(`PCGFO_ADDR_FOC, 16'h8200); clk(10);
        wr(`PCGFO_ADDR_FOC, 16'h0200);
        measure(30); chk("stopped", hi, 0); chk("pin idle", pin_out, 1'b0);
    endtask
    task automatic t_pin();
        wr(`PCGFO_ADDR_PIN, 16'h0006);
        measure(60); chk("system_clock_output rises", rc, 30);
        wr(`PCGFO_ADDR_PIN, 16'h0003); clk(4);
        chk("pin latch", pin_out, 1'b1);
        chk("pin oe", pin_oe, 1'b1);
        rd(`PCGFO_ADDR_PIN, d0); chk("pin in", d0[3], 1'b1);
        wr(`PCGFO_ADDR_PIN, 16'h0002);
    endtask
    task automatic t_lock();
        @(posedge ref_clk) end_of_init_instruction_pulse <= 1'b1;
        @(posedge ref_clk) end_of_init_instruction_pulse <= 1'b0;
        wr(`PCGFO_ADDR_PDC, 16'h0001);
        rd(`PCGFO_ADDR_PDC, d0); chk("locked", d0, 16'h0000);
        wr(`PCGFO_ADDR_REL, 16'h0009);
        wr(`PCGFO_ADDR_REL, 16'h0003);
        wr(`PCGFO_ADDR_REL, 16'h0007);
        wr(`PCGFO_ADDR_PDC, 16'h0001);
        rd(`PCGFO_ADDR_PDC, d0); chk("released", d0, 16'h0001);
        rd(`PCGFO_ADDR_REL, d0); chk("rel clr", d0, 16'h0000);
        wr(`PCGFO_ADDR_PDC, 16'h0000);
        rd(`PCGFO_ADDR_PDC, d0); chk("one write", d0, 16'h0001);
    endtask
    // Main sequence
    initial begin
        clk(16);
        @(posedge ref_clk) nrst <= 1'b1;
        t_reset();
        t_pdc();
        t_hold();
        t_programmable_freq_output();
        t_pin();
        t_lock();
        give_verdict();
    end
endmodule // pcgfo_top_tb_top
